//--- core/ldr_consts.svh
// Purpose: Offsets, field positions and reset values of the rail register bank
// Assumes: Register indices map to byte address index*4
// Notes:   Definitions only
`ifndef LDR_CONSTS_SVH
`define LDR_CONSTS_SVH

// Register indices (byte address = index * 4)
`define LDR_IDX_AUX_TWO     8'h28
`define LDR_IDX_AUX_THREE   8'h29
`define LDR_IDX_DISCH_ONE   8'h40
`define LDR_IDX_DISCH_TWO   8'h41
`define LDR_IDX_DISCH_THREE 8'h42

// Auxiliary regulator control fields
`define LDR_SLP_LSB         4
`define LDR_RSV_LSB         1
`define LDR_ALLOW_BIT       0

// Reset values
`define LDR_RST_AUX_TWO     8'h0C
`define LDR_RST_AUX_THREE   8'h3C
`define LDR_RST_DISCH_ONE   8'h55
`define LDR_RST_DISCH_TWO   8'h55
`define LDR_RST_DISCH_THREE 8'h15
`define LDR_RSV_KEEP        3'h6

// Rail count and discharge codes
`define LDR_RAILS           11
`define LDR_DISCH_NONE      2'h0

// Address bits above the index must be zero
`define LDR_ADDR_TOP_LSB    10

`endif

//--- core/ldr_pkg.sv
// Purpose: Types shared by the rail register bank
// Assumes: AHB-Lite with 32-bit data
// Notes:   Constants live in ldr_consts.svh
package ldr_pkg;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ldr_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ldr_ahb_rsp_t;

    // One auxiliary regulator control register
    typedef struct packed {
        logic [1:0] sleep_select;
        logic [2:0] reserved_keep;
        logic       allow_on;
    } ldr_aux_ctrl_t;

    // Outputs towards one auxiliary regulator
    typedef struct packed {
        logic allow_on;
        logic sleep_active;
        logic voltage_code_valid;
    } ldr_aux_out_t;

endpackage

//--- core/ldr_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs come from outside the sys_clk domain
// Notes:   Output changes once stages two and three agree
module ldr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff[i] <= 1'b0;
                    s2_ff[i] <= 1'b0;
                    s3_ff[i] <= 1'b0;
                    q[i]     <= 1'b0;
                end else if (ce) begin
                    s1_ff[i] <= d[i];
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i]) begin
                        q[i] <= s3_ff[i];
                    end
                end
            end
        end
    endgenerate

endmodule

//--- core/ldr_regs.sv
// Purpose: Auxiliary regulator control and rail discharge register bank
// Assumes: AHB-Lite slave, zero wait states, 100 MHz sys_clk
// Notes:   Rail enables and sleep pins arrive asynchronously
`include "ldr_consts.svh"

// Notes on behaviour
// - Regulator two sleep field bits 5-4, reset 0; nonzero enables sleep.
// - Regulator three sleep field resets to 3, so sleep is on from reset.
// - Sleep switching follows one of two sleep pins, chosen by factory strap.
// - Regulator two bit 0 clear forces it off whatever the control pins.
// - Regulator three bit 0 behaves alike and resets to 0, forced off.
// - Discharge fields pick none/100/200/500 ohm, reset 1, cleared while rail on.
module ldr_regs (
    // Clock, reset and clock enable
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // AHB-Lite slave
    input  wire ldr_pkg::ldr_ahb_req_t ahb_req,
    output ldr_pkg::ldr_ahb_rsp_t      ahb_rsp,
    // Pins and status from the power stage
    input  wire logic [5:0]           control_input_pins,
    input  wire logic                 sleep_pin_one,
    input  wire logic                 sleep_pin_two,
    input  wire logic                 sleep_pin_strap,
    input  wire logic [10:0]          rail_enabled,
    // Regulator controls
    output ldr_pkg::ldr_aux_out_t      aux_ldo_two,
    output ldr_pkg::ldr_aux_out_t      aux_ldo_three,
    output logic [21:0]               rail_discharge_select
);
    import ldr_pkg::*;

    typedef struct packed {
        // Software-visible registers
        ldr_aux_ctrl_t aux_two;
        ldr_aux_ctrl_t aux_three;
        logic [21:0]   disch;
        // Sleep pin choice and bus data-phase bookkeeping
        logic          strap_done;
        logic          use_pin_two;
        logic          dph_write;
        logic [7:0]    dph_idx;
        logic          dph_hit;
        // Registered outputs
        ldr_ahb_rsp_t  rsp;
        ldr_aux_out_t  out_two;
        ldr_aux_out_t  out_three;
        logic [21:0]   out_disch;
    } ldr_state_t;

    ldr_state_t st_ff;
    ldr_state_t nxt_st;

    logic [1:0]  rst_sync_ff;
    logic        rst_core_n;
    logic [12:0] pins_s;
    logic [10:0] rail_on_s;
    logic        sleep_one_s;
    logic        sleep_two_s;
    logic        addr_ok;
    logic [7:0]  a_idx;
    logic        sleep_level;
    logic [7:0]  rd_byte;

    // Reset release through two flops
    // Assertion is immediate; release is retimed so no flop sees it late
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_ff[1];

    ldr_sync #(
        .W (13)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_core_n),
        .ce      (ce),
        .d       ({sleep_pin_two, sleep_pin_one, rail_enabled}),
        .q       (pins_s)
    );
    assign rail_on_s   = pins_s[10:0];
    assign sleep_one_s = pins_s[11];
    assign sleep_two_s = pins_s[12];

    // Each enabled rail masks its own two-bit discharge field
    logic [21:0] rail_clr;
    genvar g;
    generate
        for (g = 0; g < `LDR_RAILS; g++) begin : g_rail
            assign rail_clr[2*g +: 2] = {2{rail_on_s[g]}};
        end
    endgenerate

    // Control pins only matter to the sequencer; bit 0 overrides them
    logic ctl_unused;
    assign ctl_unused = ^control_input_pins;

    assign a_idx   = ahb_req.haddr[9:2];
    assign addr_ok = ahb_req.haddr[31:`LDR_ADDR_TOP_LSB] == 22'h0;
    // Neither hsize nor haddr[1:0] is decoded: every register is one word

    always_comb begin
        nxt_st = st_ff;
        rd_byte = 8'h00;

        // Factory strap picks the sleep pin, caught once after reset
        if (!st_ff.strap_done) begin
            nxt_st.strap_done  = 1'b1;
            nxt_st.use_pin_two = sleep_pin_strap;
        end

        // Data phase of a write
        if (st_ff.dph_write && st_ff.dph_hit) begin
            unique case (st_ff.dph_idx)
                `LDR_IDX_AUX_TWO: begin
                    // Bits 7-6 are dropped on write
                    nxt_st.aux_two = ahb_req.hwdata[5:0];
                end
                `LDR_IDX_AUX_THREE: begin
                    nxt_st.aux_three = ahb_req.hwdata[5:0];
                end
                `LDR_IDX_DISCH_ONE: begin
                    nxt_st.disch[7:0] = ahb_req.hwdata[7:0];
                end
                `LDR_IDX_DISCH_TWO: begin
                    nxt_st.disch[15:8] = ahb_req.hwdata[7:0];
                end
                `LDR_IDX_DISCH_THREE: begin
                    nxt_st.disch[21:16] = ahb_req.hwdata[5:0];
                end
                default: begin
                end
            endcase
        end

        // An enabled rail holds its discharge field at zero, over writes
        nxt_st.disch = nxt_st.disch & ~rail_clr;

        // Address phase
        nxt_st.dph_write = 1'b0;
        nxt_st.dph_hit   = 1'b0;
        nxt_st.dph_idx   = a_idx;
        nxt_st.rsp.hreadyout = 1'b1;
        nxt_st.rsp.hresp     = 1'b0;
        if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
            nxt_st.dph_write = ahb_req.hwrite;
            nxt_st.dph_hit   = addr_ok;
            if (!ahb_req.hwrite) begin
                // Read reflects any write finishing in this same cycle
                if (addr_ok) begin
                    unique case (a_idx)
                        `LDR_IDX_AUX_TWO: begin
                            rd_byte = {2'h0, nxt_st.aux_two};
                        end
                        `LDR_IDX_AUX_THREE: begin
                            rd_byte = {2'h0, nxt_st.aux_three};
                        end
                        `LDR_IDX_DISCH_ONE: begin
                            rd_byte = nxt_st.disch[7:0];
                        end
                        `LDR_IDX_DISCH_TWO: begin
                            rd_byte = nxt_st.disch[15:8];
                        end
                        `LDR_IDX_DISCH_THREE: begin
                            rd_byte = {2'h0, nxt_st.disch[21:16]};
                        end
                        default: begin
                            rd_byte = 8'h00;
                        end
                    endcase
                end
                nxt_st.rsp.hrdata = {24'h0, rd_byte};
            end
        end

        // Regulator outputs
        // Every port leaves a flop, so outputs lag the registers one cycle
        sleep_level = st_ff.use_pin_two ? sleep_two_s : sleep_one_s;
        nxt_st.out_two.allow_on   = st_ff.aux_two.allow_on;
        nxt_st.out_three.allow_on = st_ff.aux_three.allow_on;
        nxt_st.out_two.sleep_active =
            (st_ff.aux_two.sleep_select != 2'h0) && sleep_level;
        nxt_st.out_three.sleep_active =
            (st_ff.aux_three.sleep_select != 2'h0) && sleep_level;
        nxt_st.out_two.voltage_code_valid =
            st_ff.aux_two.reserved_keep == `LDR_RSV_KEEP;
        nxt_st.out_three.voltage_code_valid =
            st_ff.aux_three.reserved_keep == `LDR_RSV_KEEP;
        nxt_st.out_disch = st_ff.disch;
    end

    // Clock enable low freezes the bank; a transfer taken then is lost
    always_ff @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_ff               <= '0;
            st_ff.aux_two       <= 6'(`LDR_RST_AUX_TWO);
            st_ff.aux_three     <= 6'(`LDR_RST_AUX_THREE);
            st_ff.disch[7:0]    <= `LDR_RST_DISCH_ONE;
            st_ff.disch[15:8]   <= `LDR_RST_DISCH_TWO;
            st_ff.disch[21:16]  <= 6'(`LDR_RST_DISCH_THREE);
            st_ff.out_disch[7:0]   <= `LDR_RST_DISCH_ONE;
            st_ff.out_disch[15:8]  <= `LDR_RST_DISCH_TWO;
            st_ff.out_disch[21:16] <= 6'(`LDR_RST_DISCH_THREE);
            st_ff.out_two.voltage_code_valid   <= 1'b1;
            st_ff.out_three.voltage_code_valid <= 1'b1;
            st_ff.rsp.hreadyout <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign ahb_rsp               = st_ff.rsp;
    assign aux_ldo_two           = st_ff.out_two;
    assign aux_ldo_three         = st_ff.out_three;
    assign rail_discharge_select = st_ff.out_disch;

endmodule

//--- sim/ldr_regs_sva.sv
// Purpose: Bus and output checks on the rail register bank
// Assumes: Zero wait states, outputs one cycle behind registers
// Notes:   Attached to ldr_regs by bind
`include "ldr_consts.svh"
module ldr_regs_sva (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  ce,
    // Bus
    input wire ldr_pkg::ldr_ahb_req_t ahb_req,
    input wire ldr_pkg::ldr_ahb_rsp_t ahb_rsp,
    // Rails and regulators
    input wire logic [10:0]           rail_enabled,
    input wire ldr_pkg::ldr_aux_out_t aux_ldo_two,
    input wire ldr_pkg::ldr_aux_out_t aux_ldo_three,
    input wire logic [21:0]           rail_discharge_select
);
    import ldr_pkg::*;
    localparam logic [31:0] A2 = 32'(`LDR_IDX_AUX_TWO) << 2;
    localparam logic [31:0] A3 = 32'(`LDR_IDX_AUX_THREE) << 2;
    logic tk;
    logic on7;
    assign tk = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready & ce;
    assign on7 = rail_enabled[7] & ce;
    logic wr2;
    logic wr3;
    assign wr2 = tk & ahb_req.hwrite & (ahb_req.haddr[31:2] == A2[31:2]);
    assign wr3 = tk & ahb_req.hwrite & (ahb_req.haddr[31:2] == A3[31:2]);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    okay_resp_a: assert property (ahb_rsp.hresp == 1'b0)
        else $error("response not OKAY");
    always_ready_a: assert property (ahb_rsp.hreadyout)
        else $error("wait state inserted");
    unmapped_zero_a: assert property (
        tk && !ahb_req.hwrite && ahb_req.haddr[31:10] != 0
        |=> ahb_rsp.hrdata == 0) else $error("unmapped read not zero");
    rsv_read_a: assert property (
        tk && !ahb_req.hwrite && ahb_req.haddr[31:3] == A2[31:3]
        |=> ahb_rsp.hrdata[7:6] == 2'h0) else $error("bits 7-6 set");
    disch_clear_a: assert property (
        on7 [*8] ##1 on7 [*4] |-> rail_discharge_select[15:14] == 2'h0)
        else $error("discharge kept while rail on");
    allow_follow_a: assert property (
        wr2 ##1 (ce && !wr2) ##1 ce
        |=> aux_ldo_two.allow_on == $past(ahb_req.hwdata[0], 2))
        else $error("allow_on does not follow bit 0");
    code_valid_a: assert property (
        wr3 ##1 (ce && !wr3) ##1 ce
        |=> aux_ldo_three.voltage_code_valid
            == ($past(ahb_req.hwdata[3:1], 2) == 3'h6))
        else $error("code valid wrong");
    read_back_a: assert property (
        wr3 ##1 tk && !ahb_req.hwrite && ahb_req.haddr[31:2] == A3[31:2]
        |=> ahb_rsp.hrdata[5:0] == $past(ahb_req.hwdata[5:0]))
        else $error("read back differs");
endmodule

bind ldr_regs ldr_regs_sva u_sva (.sys_clk, .rst_n, .ce, .ahb_req,
    .ahb_rsp, .rail_enabled, .aux_ldo_two, .aux_ldo_three,
    .rail_discharge_select);

//--- sim/ldo_ctrl_discharge_regs_bench.sv
// Purpose: Self-checking bench for the rail register bank
// Assumes: Zero wait states, strap picks pin one, then pin two after reset
// Notes:   One task per scenario
`include "ldr_consts.svh"
module ldo_ctrl_discharge_regs_bench import ldr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A2 = 32'(`LDR_IDX_AUX_TWO) << 2;
    localparam logic [31:0] A3 = 32'(`LDR_IDX_AUX_THREE) << 2;
    localparam logic [31:0] D1 = 32'(`LDR_IDX_DISCH_ONE) << 2;
    localparam logic [31:0] D2 = 32'(`LDR_IDX_DISCH_TWO) << 2;
    localparam logic [31:0] D3 = 32'(`LDR_IDX_DISCH_THREE) << 2;
    logic         sys_clk = 0, rst_n = 0, ce = 1, pin1 = 0, pin2 = 0;
    logic         strap = 0;
    logic [5:0]   ctl = 6'h3F;
    logic         hsel = 0, hwrite = 0;
    logic [1:0]   htrans = 0;
    logic [31:0]  haddr = 0, hwdata = 0, rd;
    logic [10:0]  rail_en = 0;
    logic [21:0]  disch;
    ldr_ahb_req_t req;
    ldr_ahb_rsp_t rsp;
    ldr_aux_out_t two, three;
    int           failures = 0, total_checks = 0;

    always #5 sys_clk = ~sys_clk;
    assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};

    ldr_regs DUT (.sys_clk, .rst_n, .ce, .ahb_req(req), .ahb_rsp(rsp),
        .control_input_pins(ctl), .sleep_pin_one(pin1),
        .sleep_pin_two(pin2), .sleep_pin_strap(strap),
        .rail_enabled(rail_en), .aux_ldo_two(two), .aux_ldo_three(three),
        .rail_discharge_select(disch));

    task print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, got);
        total_checks++;
        if (got !== ex) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.hreadyout !== 1'b1 && n < 20);
        if (rsp.hreadyout !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask
    task bus(input logic w, input logic [31:0] a, d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_rdy();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = rsp.hrdata;
    endtask
    task rdc(input string nm, input logic [31:0] a, ex);
        bus(0, a, 0);
        chk(nm, ex, rd);
    endtask
    task settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task t_reset;
        rdc("aux two", A2, 32'h0C);
        rdc("aux three", A3, 32'h3C);
        rdc("disch one", D1, 32'h55);
        rdc("disch two", D2, 32'h55);
        rdc("disch three", D3, 32'h15);
        chk("allow two", 0, two.allow_on);
        chk("allow three", 0, three.allow_on);
        chk("codes two rst", 1, two.voltage_code_valid);
        chk("codes three rst", 1, three.voltage_code_valid);
        chk("disch out", 22'h155555, disch);
    endtask
    task t_aux;
        bus(1, A2, 32'hFF);
        rdc("rsv bits", A2, 32'h3F);
        ctl <= 6'h00;
        settle(3);
        chk("allow on", 1, two.allow_on);
        chk("codes", 0, two.voltage_code_valid);
        bus(1, A3, 32'h0D);
        rdc("sleep off", A3, 32'h0D);
        settle(3);
        chk("allow three", 1, three.allow_on);
        chk("codes three", 1, three.voltage_code_valid);
        pin1 <= 1;
        for (int c = 0; c < 4; c++) begin
            bus(1, A2, {26'h0, c[1:0], 4'hD});
            settle(8);
            chk("sleep", c != 0, two.sleep_active);
        end
        chk("three off", 0, three.sleep_active);
        pin1 <= 0;
        pin2 <= 1;
        settle(8);
        chk("other pin", 0, two.sleep_active);
    endtask
    task t_disch;
        for (int c = 0; c < 4; c++) begin
            bus(1, D2, {24'h0, {4{c[1:0]}}});
            rdc("code", D2, {24'h0, {4{c[1:0]}}});
        end
        rail_en[7] <= 1;
        settle(14);
        bus(1, D2, 32'hFF);
        rdc("rail on", D2, 32'h3F);
        chk("rail field", 0, disch[15:14]);
        rail_en[7] <= 0;
        settle(8);
        bus(1, D2, 32'hFF);
        rdc("rail off", D2, 32'hFF);
    endtask
    task t_unmap;
        bus(1, 32'h200, 32'hFF);
        rdc("unmapped", 32'h200, 0);
        bus(1, A2 | 32'h400, 32'h00);
        rdc("alias", A2, 32'h3D);
        rdc("high addr", A2 | 32'h400, 0);
        chk("resp", 0, rsp.hresp);
    endtask
    task t_strap;
        rst_n <= 0;
        strap <= 1;
        ctl <= 6'h3F;
        pin1 <= 0;
        pin2 <= 1;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        settle(8);
        chk("pin two", 1, three.sleep_active);
        chk("two idle", 0, two.sleep_active);
        pin1 <= 1;
        pin2 <= 0;
        settle(8);
        chk("pin one", 0, three.sleep_active);
        ce <= 0;
        bus(1, A3, 32'h0D);
        pin2 <= 1;
        settle(8);
        chk("frozen", 0, three.sleep_active);
        ce <= 1;
        settle(8);
        chk("thawed", 1, three.sleep_active);
        rdc("lost write", A3, 32'h3C);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_aux();
        t_disch();
        t_unmap();
        t_strap();
        print_verdict();
    end
endmodule
